// ===== eawd_defines.vh
// Constants for the extender address-window decode block.
// Assumes inclusion by bare name from the design files.
`ifndef EAWD_DEFINES_VH
`define EAWD_DEFINES_VH

// Logical address width: 256 logical addresses
`define EAWD_LA_W 8
// Size field width, holds 0..8
`define EAWD_SIZE_W 4
// Size value meaning all address bits compared
`define EAWD_SIZE_FULL 4'h8
// Default extender logical address
`define EAWD_LA_DEFAULT 8'h01
// Logical-address region in A16 begins at 0xc000
`define EAWD_A16_LA_BASE 16'hc000
// Field positions of an A16 address within that region
`define EAWD_A16_LA_LSB 6
`define EAWD_A16_LA_MSB 13
`define EAWD_A16_REGION_MSB 15
`define EAWD_A16_REGION_LSB 14
`define EAWD_A16_REGION_VAL 2'h3
// Window format select values
`define EAWD_FMT_BASE_SIZE 1'b0
`define EAWD_FMT_HIGH_LOW 1'b1
// Direction values in base/size style
`define EAWD_DIR_INTO_FRAME 1'b0
`define EAWD_DIR_OUT_OF_FRAME 1'b1

`endif

// ===== eawd_window.v
// One address-mapping window: base/size or high/low range compare.
// Assumes addresses and window fields are stable within an address phase.
`timescale 1ns/1ps
`include "eawd_defines.vh"

module eawd_window #(
  parameter AW = 8
) (
  fmt_high_low,
  enable,
  base_or_high,
  size_or_low,
  size_val,
  dir_out,
  link_addr,
  bp_addr,
  hit_in,
  hit_out
);
  input wire fmt_high_low;
  input wire enable;
  input wire [AW-1:0] base_or_high;
  input wire [AW-1:0] size_or_low;
  input wire [`EAWD_SIZE_W-1:0] size_val;
  input wire dir_out;
  input wire [AW-1:0] link_addr;
  input wire [AW-1:0] bp_addr;
  output reg hit_in;
  output reg hit_out;

  // Mask of compared upper bits: size bits from the top, rest treated as zero.
  // Sizes above full width saturate, so a stray size never opens the whole space.
  function [AW-1:0] eawd_size_mask;
    input [`EAWD_SIZE_W-1:0] sz;
    integer i;
    integer n;
    begin
      n = {{(32-`EAWD_SIZE_W){1'b0}}, sz};
      if (n > AW)
        n = AW;
      eawd_size_mask = {AW{1'b0}};
      for (i = 0; i < AW; i = i + 1) begin
        if (i >= AW - n)
          eawd_size_mask[i] = 1'b1;
      end
    end
  endfunction

  // Inclusive range test with arbitrary bounds
  function eawd_in_range;
    input [AW-1:0] a;
    input [AW-1:0] lo;
    input [AW-1:0] hi;
    begin
      eawd_in_range = (a >= lo) && (a <= hi); // RQ15 RQ5
    end
  endfunction

  reg [AW-1:0] mask;
  reg hl_zero;
  reg hl_inward;

  always @* begin
    mask = eawd_size_mask(size_val); // RQ13 RQ8
    hl_zero = (base_or_high == {AW{1'b0}}) && (size_or_low == {AW{1'b0}});
    hl_inward = (base_or_high >= size_or_low);
    hit_in = 1'b0;
    hit_out = 1'b0;
    if (enable) begin
      if (fmt_high_low == `EAWD_FMT_HIGH_LOW) begin // RQ1
        if (!hl_zero) begin // RQ4
          if (hl_inward)
            hit_in = eawd_in_range(link_addr, size_or_low, base_or_high); // RQ2
          else
            hit_out = eawd_in_range(bp_addr, base_or_high, size_or_low); // RQ3
        end
      end else begin
        // Aligned power-of-two block selected by masked compare
        if (dir_out == `EAWD_DIR_OUT_OF_FRAME) // RQ12
          hit_out = ((bp_addr & mask) == (base_or_high & mask)); // RQ7
        else
          hit_in = ((link_addr & mask) == (base_or_high & mask)); // RQ7
      end
    end
  end
endmodule // eawd_window

// ===== eawd_decode.v
// Address-window decode of a backplane-to-cable mainframe extender.
// Assumes window fields come from a configuration master via plain ports,
// and all inputs are synchronous to clock.
//
// Overview of operation
// [RQ1] Format select one picks high/low style
// [RQ2] High above low passes link addresses inward
// [RQ3] Low above high forwards backplane addresses out
// [RQ4] Both bounds zero disables the window
// [RQ5] High/low bounds take any values, no rounding
// [RQ6] Logical address space holds 256 addresses
// [RQ7] Base/size covers aligned power-of-two blocks
// [RQ8] Size value is eight minus log2 length
// [RQ9] Own registers decoded at logical address
// [RQ10] Other devices avoid the logical address region
// [RQ11] Logical address defaults to one, changeable
// [RQ12] Format zero uses base/size with direction
// [RQ13] Size gives compared upper base bits
// [RQ14] All windows off after initialization
// [RQ15] Range compare includes both bounds
// [RQ16] Hits evaluated without extra pipeline cycles
`timescale 1ns/1ps
`include "eawd_defines.vh"

module eawd_decode #(
  parameter NWIN = 4,
  parameter AW = `EAWD_LA_W
) (
  clock,
  rst_n,
  window_format_select,
  win_load,
  win_enable,
  win_base_or_high,
  win_size_or_low,
  win_size,
  win_dir_out,
  la_load,
  la_value,
  link_addr,
  bp_addr,
  a16_addr,
  addr_phase,
  hit_in,
  hit_out,
  any_hit_in,
  any_hit_out,
  own_reg_sel,
  own_la
);
  input wire clock;
  input wire rst_n;
  input wire window_format_select;
  input wire win_load;
  input wire [NWIN-1:0] win_enable;
  input wire [NWIN*AW-1:0] win_base_or_high;
  input wire [NWIN*AW-1:0] win_size_or_low;
  input wire [NWIN*`EAWD_SIZE_W-1:0] win_size;
  input wire [NWIN-1:0] win_dir_out;
  input wire la_load;
  input wire [AW-1:0] la_value;
  input wire [AW-1:0] link_addr;
  input wire [AW-1:0] bp_addr;
  input wire [15:0] a16_addr;
  input wire addr_phase;
  output reg [NWIN-1:0] hit_in;
  output reg [NWIN-1:0] hit_out;
  output reg any_hit_in;
  output reg any_hit_out;
  output reg own_reg_sel;
  output reg [AW-1:0] own_la;

  ////////////////////////////////////////////////////////////////////////////
  // Window configuration held as the extender control state

  reg fmt_q;
  reg [NWIN-1:0] en_q;
  reg [NWIN*AW-1:0] boh_q;
  reg [NWIN*AW-1:0] sol_q;
  reg [NWIN*`EAWD_SIZE_W-1:0] size_q;
  reg [NWIN-1:0] dir_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fmt_q <= `EAWD_FMT_BASE_SIZE;
      en_q <= {NWIN{1'b0}}; // RQ14
      boh_q <= {(NWIN*AW){1'b0}};
      sol_q <= {(NWIN*AW){1'b0}};
      size_q <= {(NWIN*`EAWD_SIZE_W){1'b0}};
      dir_q <= {NWIN{1'b0}};
    end else if (win_load) begin
      fmt_q <= window_format_select;
      en_q <= win_enable;
      boh_q <= win_base_or_high;
      sol_q <= win_size_or_low;
      size_q <= win_size;
      dir_q <= win_dir_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Extender logical address, changeable so several modules stay distinct

  reg [AW-1:0] la_q;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      la_q <= `EAWD_LA_DEFAULT; // RQ11
    else if (la_load)
      la_q <= la_value; // RQ11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-window combinational compare, one result per address phase

  wire [NWIN-1:0] hit_in_c;
  wire [NWIN-1:0] hit_out_c;

  genvar g;
  generate
    for (g = 0; g < NWIN; g = g + 1) begin : g_win
      eawd_window #(
        .AW(AW)
      ) u_win (
        .fmt_high_low(fmt_q),
        .enable(en_q[g]),
        .base_or_high(boh_q[g*AW +: AW]),
        .size_or_low(sol_q[g*AW +: AW]),
        .size_val(size_q[g*`EAWD_SIZE_W +: `EAWD_SIZE_W]),
        .dir_out(dir_q[g]),
        .link_addr(link_addr), // RQ6
        .bp_addr(bp_addr), // RQ6
        .hit_in(hit_in_c[g]),
        .hit_out(hit_out_c[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Own register decode in A16 logical-address region

  wire own_sel_c;

  assign own_sel_c = (a16_addr[`EAWD_A16_REGION_MSB:`EAWD_A16_REGION_LSB] ==
                      `EAWD_A16_REGION_VAL) &&
                     (a16_addr[`EAWD_A16_LA_MSB:`EAWD_A16_LA_LSB] == la_q); // RQ9

  ////////////////////////////////////////////////////////////////////////////
  // Output registers: hits and own select sampled at the address phase, cleared otherwise; own_la follows la_q every cycle

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hit_in <= {NWIN{1'b0}};
      hit_out <= {NWIN{1'b0}};
      any_hit_in <= 1'b0;
      any_hit_out <= 1'b0;
      own_reg_sel <= 1'b0;
      own_la <= `EAWD_LA_DEFAULT;
    end else begin
      own_la <= la_q;
      if (addr_phase) begin
        hit_in <= hit_in_c; // RQ16
        hit_out <= hit_out_c; // RQ16
        any_hit_in <= |hit_in_c;
        any_hit_out <= |hit_out_c;
        own_reg_sel <= own_sel_c;
      end else begin
        hit_in <= {NWIN{1'b0}};
        hit_out <= {NWIN{1'b0}};
        any_hit_in <= 1'b0;
        any_hit_out <= 1'b0;
        own_reg_sel <= 1'b0;
      end
    end
  end
endmodule // eawd_decode

// ===== eawd_chk.sv
// Checker for the address-window decode block.
// Assumes a bind onto eawd_decode and a single clock domain.
`timescale 1ns/1ps
module eawd_chk #(
  parameter NWIN = 4,
  parameter AW = 8
) (
  input wire clock,
  input wire rst_n,
  input wire win_load,
  input wire [NWIN-1:0] win_enable,
  input wire la_load,
  input wire [AW-1:0] la_value,
  input wire [15:0] a16_addr,
  input wire addr_phase,
  input wire [NWIN-1:0] hit_in,
  input wire [NWIN-1:0] hit_out,
  input wire any_hit_in,
  input wire any_hit_out,
  input wire own_reg_sel,
  input wire [AW-1:0] own_la
);
  reg [NWIN-1:0] en_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= {NWIN{1'b0}};
    end else if (win_load) begin
      en_q <= win_enable;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence la_take;
    la_load ##2 1'b1;
  endsequence
  sequence all_quiet;
    hit_in == 0 && hit_out == 0 && !own_reg_sel;
  endsequence
  sequence own_match;
    own_reg_sel == ($past(a16_addr[15:14]) == 2'h3 && $past(a16_addr[13:6]) == own_la);
  endsequence
  idle_clear_a: assert property (!addr_phase |=> all_quiet)
    else $error("hit without address phase");
  any_in_a: assert property (any_hit_in == |hit_in)
    else $error("any_hit_in not OR of hits");
  any_out_a: assert property (any_hit_out == |hit_out)
    else $error("any_hit_out not OR of hits");
  dir_excl_a: assert property ((hit_in & hit_out) == 0)
    else $error("window hit both ways");
  en_gate_a: assert property (addr_phase |=> ((hit_in | hit_out) & ~$past(en_q)) == 0)
    else $error("disabled window hit");
  own_sel_a: assert property (addr_phase |=> own_match)
    else $error("own register select wrong");
  la_take_a: assert property (la_take |-> own_la == $past(la_value, 2))
    else $error("logical address not loaded");
  la_reset_a: assert property ($rose(rst_n) |-> own_la == 8'h01)
    else $error("logical address reset wrong");
endmodule // eawd_chk
bind eawd_decode eawd_chk #(.NWIN(NWIN), .AW(AW)) i_eawd_chk (.*);

// ===== eawd_link_model.sv
// Far-side model: a remote frame presenting logical addresses.
// Assumes one clock; steps by one so that window bounds get swept.
`timescale 1ns/1ps
module eawd_link_model (
  input wire clock,
  input wire rst_n,
  output reg [7:0] link_addr
);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_addr <= 8'h00;
    end else begin
      link_addr <= link_addr + 8'h01;
    end
  end
endmodule // eawd_link_model

// ===== tb.sv
// Self-checking bench for the address-window decode block.
// Assumes the link model drives link_addr and the checker is bound.
`timescale 1ns/1ps
module tb;
  reg clock = 1'b0, rst_n = 1'b0, fmt = 1'b0, wl = 1'b0, ll = 1'b0, ph = 1'b0, off = 1'b1;
  reg [3:0] en = 4'h0, dr = 4'h0, ei = 4'h0, eo = 4'h0;
  reg [31:0] f1 = 32'h0, f2 = 32'h0;
  reg [15:0] sz = 16'h0, a16 = 16'h0;
  reg [7:0] lv = 8'h0, bp = 8'h0, cur = 8'h01, lag = 8'h01;
  reg es = 1'b0;
  wire [7:0] la, ol;
  wire [3:0] hi, ho;
  wire ai, ao, os;
  integer miscompares = 0, n_checks = 0, cyc = 0, t, k, g;
  always #5 clock = ~clock;
  eawd_decode i_eawd_decode (.clock(clock), .rst_n(rst_n), .window_format_select(fmt),
    .win_load(wl), .win_enable(en), .win_base_or_high(f1), .win_size_or_low(f2),
    .win_size(sz), .win_dir_out(dr), .la_load(ll), .la_value(lv), .link_addr(la),
    .bp_addr(bp), .a16_addr(a16), .addr_phase(ph), .hit_in(hi), .hit_out(ho),
    .any_hit_in(ai), .any_hit_out(ao), .own_reg_sel(os), .own_la(ol));
  eawd_link_model i_eawd_link_model (.clock(clock), .rst_n(rst_n), .link_addr(la));
  ////////////////////////////////////////
  function [1:0] exp_hit(input hl, e, input [7:0] h, l, input [3:0] s, input d, input [7:0] a, b);
    reg [7:0] m;
    begin
      m = ~(8'hff >> ((s > 4'h8) ? 4'h8 : s));
      if (!e) exp_hit = 2'b00;
      else if (hl) begin
        if (h == 8'h00 && l == 8'h00) exp_hit = 2'b00;
        else if (h >= l) exp_hit = {a >= l && a <= h, 1'b0};
        else exp_hit = {1'b0, b >= h && b <= l};
      end else exp_hit = d ? {1'b0, (b & m) == (h & m)} : {(a & m) == (h & m), 1'b0};
    end
  endfunction
  task check(input [8*6:1] what, input [7:0] seen, exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected %0s: expected %h, seen %h", what, exp, seen);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  ////////////////////////////////////////
  task do_reset;
    begin
      rst_n = 1'b0;
      ph = 1'b0;
      wl = 1'b0;
      ll = 1'b0;
      off = 1'b1;
      cur = 8'h01;
      lag = 8'h01;
      {ei, eo, es} = 9'h0;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      check("own_la", ol, 8'h01);
    end
  endtask
  // Load step programs random windows; other steps decode one phase, or idle when ph stays low
  task step(input ld);
    begin
      @(negedge clock);
      check("hit_in", {4'h0, hi}, {4'h0, ei});
      check("hitout", {4'h0, ho}, {4'h0, eo});
      check("ownsel", {7'h0, os}, {7'h0, es});
      check("anyhit", {6'h0, ai, ao}, {6'h0, |ei, |eo});
      check("own_la", ol, lag);
      lag = cur;
      wl = ld;
      ll = 1'b0;
      ph = 1'b0;
      {ei, eo, es} = 9'h0;
      if (ld) begin
        {fmt, en, dr, sz} = {$urandom, $urandom};
        off = 1'b0;
        for (g = 0; g < 4; g = g + 1) begin
          f1[g*8+:8] = ($urandom % 3) ? la + $urandom % 12 : 8'h00;
          f2[g*8+:8] = ($urandom % 3) ? la + $urandom % 12 : 8'h00;
        end
      end else begin
        ph = ($urandom % 4) != 0;
        ll = ($urandom % 6) == 0;
        lv = $urandom;
        g = $urandom % 4;
        bp = ($urandom % 2) ? f1[g*8+:8] : f2[g*8+:8];
        a16 = $urandom;
        if ($urandom % 2) a16[13:6] = cur;
        // Addresses below the logical region stand for other backplane devices
        if ($urandom % 4) a16[15:14] = 2'h3;
        for (g = 0; g < 4; g = g + 1) begin
          {ei[g], eo[g]} = ph ? exp_hit(fmt, en[g] & ~off, f1[g*8+:8], f2[g*8+:8],
            sz[g*4+:4], dr[g], la, bp) : 2'b00;
        end
        es = ph && a16[15:14] == 2'h3 && a16[13:6] == cur;
        if (ll) cur = lv;
      end
    end
  endtask
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      wrap_up;
    end
  end
  initial begin
    k = $urandom(32'h528112f0);
    for (t = 0; t < 24; t = t + 1) begin
      if (t % 12 == 0) do_reset;
      for (k = 0; k < 14; k = k + 1) step(k == 3);
      $display("test %0d done", t);
    end
    wrap_up;
  end
endmodule // tb
